// File: cssb_pkg.sv
/*
  Shared constants, register layouts and types for the clock select and
  supply status register bank. Assumes a 40 MHz core clock.
*/
package cssb_pkg;

  // register port
  localparam int unsigned ADDR_W = 5;
  localparam logic [ADDR_W-1:0] CLK_CFG_ADDR = 5'h1d;
  localparam logic [ADDR_W-1:0] STATUS_ADDR = 5'h1e;
  localparam logic [7:0] CLK_CFG_RESET = 8'h00;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] READ_IDLE = 8'h00;
  // bit 5 of the clock register is read-only
  localparam logic [7:0] CLK_CFG_WR_MASK = 8'hdf;

  // timing
  localparam int unsigned CORE_PERIOD_NS = 25;
  // no edge for this long marks a source missing
  localparam int unsigned MISS_TIME_NS = 1000;
  localparam int unsigned MISS_CYCLES = (MISS_TIME_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
  localparam int unsigned MISS_CNT_W = 8;
  localparam logic [MISS_CNT_W-1:0] MISS_LIMIT = MISS_CNT_W'(MISS_CYCLES);
  // fallback clock output half period, rounded down
  localparam int unsigned INT_HALF_NS = 135;
  localparam int unsigned INT_HALF_CYCLES = INT_HALF_NS / CORE_PERIOD_NS;
  localparam int unsigned INT_CNT_W = 4;
  localparam logic [INT_CNT_W-1:0] INT_LIMIT = INT_CNT_W'(INT_HALF_CYCLES - 1);
  // host settle time before reading the missing flag
  localparam int unsigned HOST_SETTLE_MS = 100;

  // divider codes and source edges per output half period
  localparam logic [1:0] DIV_FAST = 2'h0;
  localparam logic [1:0] DIV_MID = 2'h1;
  localparam int unsigned EDGE_CNT_W = 3;
  localparam logic [EDGE_CNT_W-1:0] EDGES_FAST = 3'h4;
  localparam logic [EDGE_CNT_W-1:0] EDGES_MID = 3'h2;
  localparam logic [EDGE_CNT_W-1:0] EDGES_SLOW = 3'h1;

  typedef enum logic [1:0] {
    SRC_INTERNAL,
    SRC_CRYSTAL,
    SRC_EXTERNAL
  } cssb_src_t;

  typedef struct packed {
    logic supply_warn_irq_en;
    logic pin_drive_override;
    logic external_clock_missing;
    logic clock_out_enable;
    logic [1:0] crystal_divider_select;
    logic external_clock_input_enable;
    logic crystal_osc_enable;
  } cssb_clk_cfg_t;

  typedef struct packed {
    logic thermal_off;
    logic thermal_warn;
    logic supply_uv;
    logic supply_warn;
  } cssb_flags_t;

  typedef struct packed {
    cssb_flags_t latched;
    cssb_flags_t live;
  } cssb_status_t;

  // analog comparator outputs, asynchronous to the core clock
  typedef struct packed {
    logic thermal_off_in;
    logic temp_above_warn;
    logic temp_below_release;
    logic supply_below_uv;
    logic supply_below_warn;
    logic supply_above_release;
  } cssb_sense_t;

endpackage

// File: cssb_sync.sv
/*
  Two-flop synchroniser for a vector of asynchronous levels.
  Assumes each bit is an independent level; no bus coherence is given.
*/
`timescale 1ns/1ps
module cssb_sync #(
  parameter int unsigned W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      sync_out <= '0;
    end else if (ce) begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule

// File: cssb_clk_mon.sv
/*
  Activity monitor for one sampled clock source: flags any edge and flags
  the source missing after LIMIT+1 cycles without an edge.
  Assumes level is already synchronised to clk.
*/
`timescale 1ns/1ps
module cssb_clk_mon #(
  parameter int unsigned CNT_W = 8,
  parameter logic [CNT_W-1:0] LIMIT = 8'h28
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic enable,
  input wire logic level,
  output logic edge_seen,
  output logic missing
);
  logic prev_q;
  logic [CNT_W-1:0] cnt_q;

  assign edge_seen = level ^ prev_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_q <= 1'b0;
      cnt_q <= '0;
      missing <= 1'b0;
    end else if (ce) begin
      prev_q <= level;
      if (!enable || edge_seen) begin
        cnt_q <= '0;
        missing <= 1'b0;
      end else if (cnt_q == LIMIT) begin
        missing <= 1'b1;
      end else begin
        cnt_q <= cnt_q + 1'b1;
      end
    end
  end
endmodule

// File: cssb_top.sv
/*
  Clock source configuration and supply/thermal status registers, with
  clock source selection, clock output, line drive override and status
  interrupt. Assumes the serial register port is decoded into same-clock
  address and strobes; comparators, clock pins and line pins are async.
*/
`timescale 1ns/1ps
module cssb_top #(
  parameter int unsigned NUM_CH = 2
) (
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic NRST,
  input wire logic CE,
  // register port
  input wire logic [cssb_pkg::ADDR_W-1:0] REG_ADDR,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [7:0] REG_WDATA,
  output logic [7:0] REG_RDATA,
  // clock sources
  input wire logic XTAL_CLK_IN,
  input wire logic CLOCK_INPUT_PIN,
  output logic CLOCK_OUTPUT_PIN,
  output cssb_pkg::cssb_src_t CORE_CLK_SEL,
  output logic XTAL_OSC_ON,
  // supply and thermal sensing
  input wire cssb_pkg::cssb_sense_t SENSE,
  output logic STATUS_IRQ,
  // line drive
  input wire logic [NUM_CH-1:0] TRANSMIT_PIN,
  input wire logic [NUM_CH-1:0] TRANSMIT_DRIVE_PIN,
  input wire logic [NUM_CH-1:0] TRANSMIT_SOFT_BIT,
  input wire logic [NUM_CH-1:0] TRANSMIT_DRIVE_SOFT_BIT,
  output logic [NUM_CH-1:0] LINE_TX,
  output logic [NUM_CH-1:0] LINE_TX_ENABLE
);
  import cssb_pkg::*;

  localparam int unsigned SYNC_W = $bits(cssb_sense_t) + 2 + 2 * NUM_CH;

  cssb_clk_cfg_t cfg_q;
  cssb_flags_t live_q;
  cssb_flags_t live_d;
  cssb_flags_t lat_q;
  cssb_flags_t lat_d;
  cssb_flags_t rise_w;
  cssb_src_t src_q;
  cssb_src_t src_req;
  logic miss_flag_q;
  logic irq_d;
  logic phase_q;
  logic [EDGE_CNT_W-1:0] edge_cnt_q;
  logic [INT_CNT_W-1:0] int_cnt_q;
  logic [SYNC_W-1:0] sync_w;
  cssb_sense_t sense_s;
  logic xtal_s;
  logic clock_input_pin_s;
  logic [NUM_CH-1:0] pin_tx_s;
  logic [NUM_CH-1:0] pin_transmit_drive_pin_s;
  logic xtal_edge;
  logic xtal_miss;
  logic ext_edge;
  logic ext_miss;

  // pin synchronisation
  cssb_sync #(
    .W(SYNC_W)
  ) u_sync (
    .clk(CORE_CLK),
    .rst_n(NRST),
    .ce(CE),
    .async_in({SENSE, XTAL_CLK_IN, CLOCK_INPUT_PIN, TRANSMIT_PIN, TRANSMIT_DRIVE_PIN}),
    .sync_out(sync_w)
  );
  assign {sense_s, xtal_s, clock_input_pin_s, pin_tx_s, pin_transmit_drive_pin_s} = sync_w;

  // keep watching the running source until the switch away is done
  wire xtal_watch = cfg_q.crystal_osc_enable || (src_q == SRC_CRYSTAL);
  wire ext_watch = cfg_q.external_clock_input_enable || (src_q == SRC_EXTERNAL);

  // source activity monitors
  cssb_clk_mon #(
    .CNT_W(MISS_CNT_W),
    .LIMIT(MISS_LIMIT)
  ) u_xtal_mon (
    .clk(CORE_CLK),
    .rst_n(NRST),
    .ce(CE),
    .enable(xtal_watch),
    .level(xtal_s),
    .edge_seen(xtal_edge),
    .missing(xtal_miss)
  );

  cssb_clk_mon #(
    .CNT_W(MISS_CNT_W),
    .LIMIT(MISS_LIMIT)
  ) u_ext_mon (
    .clk(CORE_CLK),
    .rst_n(NRST),
    .ce(CE),
    .enable(ext_watch),
    .level(clock_input_pin_s),
    .edge_seen(ext_edge),
    .missing(ext_miss)
  );

  // register decode
  wire cfg_write = REG_WR && (REG_ADDR == CLK_CFG_ADDR);
  wire status_read = REG_RD && (REG_ADDR == STATUS_ADDR);
  wire [7:0] cfg_read = {cfg_q[7:6], miss_flag_q, cfg_q[4:0]};
  wire [7:0] read_mux = (REG_ADDR == CLK_CFG_ADDR) ? cfg_read :
                        (REG_ADDR == STATUS_ADDR) ? {lat_q, live_q} : READ_IDLE;

  // source selection; both enables set is treated as neither
  wire want_xtal = cfg_q.crystal_osc_enable && !cfg_q.external_clock_input_enable;
  wire want_ext = cfg_q.external_clock_input_enable && !cfg_q.crystal_osc_enable;
  wire sel_miss_w = (want_xtal && xtal_miss) || (want_ext && ext_miss);
  wire cur_miss_w = ((src_q == SRC_CRYSTAL) && xtal_miss) ||
                    ((src_q == SRC_EXTERNAL) && ext_miss);
  assign src_req = sel_miss_w ? SRC_INTERNAL :
                   want_xtal ? SRC_CRYSTAL :
                   want_ext ? SRC_EXTERNAL : SRC_INTERNAL;
  // change only while output low, or when the old source is dead anyway
  wire switch_ok = !phase_q || cur_miss_w;
  wire src_change = (src_req != src_q) && switch_ok;

  // clock output divider
  wire int_tick = (int_cnt_q == INT_LIMIT);
  wire src_tick = (src_q == SRC_CRYSTAL) ? xtal_edge :
                  (src_q == SRC_EXTERNAL) ? ext_edge : int_tick;
  wire [EDGE_CNT_W-1:0] div_edges =
    (cfg_q.crystal_divider_select == DIV_FAST) ? EDGES_FAST :
    (cfg_q.crystal_divider_select == DIV_MID) ? EDGES_MID : EDGES_SLOW;
  wire [EDGE_CNT_W-1:0] edge_thresh = (src_q == SRC_INTERNAL) ? EDGES_SLOW : div_edges;
  wire [EDGE_CNT_W-1:0] edge_next = edge_cnt_q + 1'b1;
  wire half_done = src_tick && (edge_next >= edge_thresh);

  // live flags; the two warnings with hysteresis, the others follow their comparators
  wire thermal_warn_d = sense_s.temp_above_warn ? 1'b1 :
                        sense_s.temp_below_release ? 1'b0 : live_q.thermal_warn;
  wire supply_warn_d = sense_s.supply_below_warn ? 1'b1 :
                       sense_s.supply_above_release ? 1'b0 : live_q.supply_warn;
  assign live_d = '{
    thermal_off: sense_s.thermal_off_in,
    thermal_warn: thermal_warn_d,
    supply_uv: sense_s.supply_below_uv,
    supply_warn: supply_warn_d
  };

  // latched flags: set beats a clearing read
  assign rise_w = live_d & ~live_q;
  assign lat_d = (status_read ? cssb_flags_t'('0) : lat_q) | rise_w;
  assign irq_d = lat_d.thermal_off || lat_d.thermal_warn || lat_d.supply_uv ||
                 (lat_d.supply_warn && cfg_q.supply_warn_irq_en);

  // line drive selection
  wire [NUM_CH-1:0] tx_sel = cfg_q.pin_drive_override ? TRANSMIT_SOFT_BIT : pin_tx_s;
  wire [NUM_CH-1:0] transmit_drive_pin_sel = cfg_q.pin_drive_override ?
                               TRANSMIT_DRIVE_SOFT_BIT : pin_transmit_drive_pin_s;

  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      cfg_q <= cssb_clk_cfg_t'(CLK_CFG_RESET);
      {lat_q, live_q} <= STATUS_RESET;
      miss_flag_q <= 1'b0;
      REG_RDATA <= READ_IDLE;
      STATUS_IRQ <= 1'b0;
    end else if (CE) begin
      if (cfg_write) begin
        cfg_q <= cssb_clk_cfg_t'(REG_WDATA & CLK_CFG_WR_MASK);
      end
      live_q <= live_d;
      lat_q <= lat_d;
      miss_flag_q <= sel_miss_w;
      if (REG_RD) begin
        REG_RDATA <= read_mux;
      end
      STATUS_IRQ <= irq_d;
    end
  end

  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      src_q <= SRC_INTERNAL;
      phase_q <= 1'b0;
      edge_cnt_q <= '0;
      int_cnt_q <= '0;
      CLOCK_OUTPUT_PIN <= 1'b0;
    end else if (CE) begin
      int_cnt_q <= int_tick ? '0 : int_cnt_q + 1'b1;
      if (src_change) begin
        src_q <= src_req;
        phase_q <= 1'b0;
        edge_cnt_q <= '0;
      end else if (half_done) begin
        phase_q <= !phase_q;
        edge_cnt_q <= '0;
      end else if (src_tick) begin
        edge_cnt_q <= edge_next;
      end
      CLOCK_OUTPUT_PIN <= cfg_q.clock_out_enable && phase_q;
    end
  end

  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      LINE_TX <= '0;
      LINE_TX_ENABLE <= '0;
    end else if (CE) begin
      LINE_TX <= tx_sel;
      LINE_TX_ENABLE <= transmit_drive_pin_sel;
    end
  end

  assign CORE_CLK_SEL = src_q;
  assign XTAL_OSC_ON = cfg_q.crystal_osc_enable;

  // checks
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (!NRST);

  sequence warn_only_s;
    CE && (lat_d == 4'b0001) && !cfg_q.supply_warn_irq_en;
  endsequence

  sequence thermal_rise_s;
    CE && rise_w.thermal_off;
  endsequence

  warn_irq_gate_a: assert property (warn_only_s |=> !STATUS_IRQ)
    else $error("warning interrupt raised while disabled");
  override_tx_a: assert property (CE && cfg_q.pin_drive_override |=>
    LINE_TX == $past(TRANSMIT_SOFT_BIT))
    else $error("line output not from soft bit under override");
  fallback_src_a: assert property (CE && sel_miss_w |=>
    (src_q == SRC_INTERNAL) && miss_flag_q)
    else $error("missing source did not fall back to internal");
  clkout_off_a: assert property (CE && !cfg_q.clock_out_enable |=> !CLOCK_OUTPUT_PIN)
    else $error("clock output active while disabled");
  latch_set_a: assert property (thermal_rise_s |=> lat_q.thermal_off ##0 STATUS_IRQ)
    else $error("thermal shutdown rise not latched with interrupt");
  latch_hold_a: assert property (CE && !status_read && !rise_w.thermal_warn |=>
    lat_q.thermal_warn == $past(lat_q.thermal_warn))
    else $error("latched thermal warning changed without cause");
  irq_cause_a: assert property (STATUS_IRQ |-> (lat_q != 4'h0))
    else $error("interrupt without a latched flag");
  read_clear_a: assert property (CE && status_read && (rise_w == 4'h0) |=>
    (lat_q == 4'h0) && (live_q == $past(live_d)))
    else $error("status read did not clear latched flags");
  thermal_hyst_a: assert property (CE && live_q.thermal_warn &&
    !sense_s.temp_below_release |=> live_q.thermal_warn)
    else $error("thermal warning cleared above release level");
  supply_hyst_a: assert property (CE && live_q.supply_warn &&
    !sense_s.supply_above_release |=> live_q.supply_warn)
    else $error("supply warning cleared below release level");
  pin_path_a: assert property (CE && !cfg_q.pin_drive_override |=>
    LINE_TX_ENABLE == $past(pin_transmit_drive_pin_s))
    else $error("drive enable not from pin without override");
  glitch_free_a: assert property ($changed(src_q) |->
    !$past(phase_q) || $past(cur_miss_w))
    else $error("clock source switched while output high");

  sequence status_read_s;
    CE && status_read;
  endsequence

  read_data_a: assert property (status_read_s |=>
    REG_RDATA == {$past(lat_q), $past(live_q)})
    else $error("status read returned wrong flags");
  warn_latch_a: assert property (CE && rise_w.supply_warn |=>
    lat_q.supply_warn)
    else $error("supply warning rise not latched");
  warn_irq_on_a: assert property (CE && lat_d.supply_warn &&
    cfg_q.supply_warn_irq_en |=> STATUS_IRQ)
    else $error("enabled supply warning gave no interrupt");
  shutdown_follow_a: assert property (CE |=>
    live_q.thermal_off == $past(sense_s.thermal_off_in))
    else $error("thermal shutdown flag not following condition");
  uv_follow_a: assert property (CE |=>
    live_q.supply_uv == $past(sense_s.supply_below_uv))
    else $error("undervoltage flag not following comparator");
  soft_enable_a: assert property (CE && cfg_q.pin_drive_override |=>
    LINE_TX_ENABLE == $past(TRANSMIT_DRIVE_SOFT_BIT))
    else $error("drive enable not from soft bit under override");
  internal_default_a: assert property (CE && !want_xtal && !want_ext && !phase_q |=>
    src_q == SRC_INTERNAL)
    else $error("internal clock not selected with no source enabled");
  osc_enable_a: assert property (CE && cfg_write |=>
    XTAL_OSC_ON == $past(REG_WDATA[0]))
    else $error("oscillator enable not following written bit");
endmodule

// File: cssb_host.sv
/*
  Host model on the parallel register port of cssb_top.
  Assumes strobes are sampled at rising clk, read data one edge later.
*/
`timescale 1ns/1ps
module cssb_host #(
  parameter int unsigned SETTLE_CYC = 64
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // register port
  output logic [cssb_pkg::ADDR_W-1:0] addr,
  output logic wr,
  output logic rd,
  output logic [7:0] wdata,
  input wire logic [7:0] rdata
);
  import cssb_pkg::*;
  int up_cnt;
  initial begin
    addr = '0;
    wr = 1'b0;
    rd = 1'b0;
    wdata = '0;
  end
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      up_cnt <= 0;
    end else begin
      up_cnt <= up_cnt + 1;
    end
  end
  task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wr <= 1'b1;
    // never both source enables; zero when neither used
    wdata <= {d[7:1], d[0] & ~d[1]};
    @(posedge clk);
    wr <= 1'b0;
    addr <= ~a;
    wdata <= ~wdata;
  endtask
  task automatic rd_reg(input logic [ADDR_W-1:0] a, output logic [7:0] d);
    // missing flag meaningless until the settle time is over
    while (a == CLK_CFG_ADDR && up_cnt < SETTLE_CYC) begin
      @(posedge clk);
    end
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    addr <= ~a;
    #1 d = rdata;
  endtask
endmodule

// File: clock_select_and_supply_status_test.sv
/*
  Self-checking bench for cssb_top with a host model and a status model.
  Assumes cssb_host and the design are compiled first.
*/
`timescale 1ns/1ps
module clock_select_and_supply_status_test;
  import cssb_pkg::*;
  logic core_clk = 0, nrst = 0, xtal = 0, ext = 0, xtal_run = 1, ext_run = 1, ce = 1;
  logic [3:0] held;
  logic [ADDR_W-1:0] reg_addr;
  logic reg_wr, reg_rd, clk_out, xtal_on, irq, prv;
  logic [7:0] reg_wdata, reg_rdata, rv;
  cssb_src_t clk_sel;
  cssb_sense_t sense = '0;
  logic [1:0] tx_pin = 0, drv_pin = 0, tx_soft = 0, drv_soft = 0, line_tx, line_en;
  int n_fail = 0, tests_run = 0, seed = 32'h7750, live = 0, lat = 0, cfg = 0;
  int cnt, k, ph = 0;
  int divs[5] = '{20, 40, 80, 80, 0};
  always #12.5 core_clk = ~core_clk;
  // source clocks: one edge every 3 core cycles
  always @(posedge core_clk) begin
    ph <= (ph == 2) ? 0 : ph + 1;
    if (ph == 2 && xtal_run) begin
      xtal <= ~xtal;
    end
    if (ph == 2 && ext_run) begin
      ext <= ~ext;
    end
  end
  cssb_top DUT (.CORE_CLK(core_clk), .NRST(nrst), .CE(ce), .REG_ADDR(reg_addr),
    .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata),
    .XTAL_CLK_IN(xtal), .CLOCK_INPUT_PIN(ext), .CLOCK_OUTPUT_PIN(clk_out),
    .CORE_CLK_SEL(clk_sel), .XTAL_OSC_ON(xtal_on), .SENSE(sense), .STATUS_IRQ(irq),
    .TRANSMIT_PIN(tx_pin), .TRANSMIT_DRIVE_PIN(drv_pin), .TRANSMIT_SOFT_BIT(tx_soft),
    .TRANSMIT_DRIVE_SOFT_BIT(drv_soft), .LINE_TX(line_tx), .LINE_TX_ENABLE(line_en));
  cssb_host u_host (.clk(core_clk), .rst_n(nrst), .addr(reg_addr), .wr(reg_wr),
    .rd(reg_rd), .wdata(reg_wdata), .rdata(reg_rdata));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    if (n_fail == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  initial begin
    #(25 * 90000);
    n_fail++;
    print_verdict();
  end
  initial begin
    repeat (6) @(posedge core_clk);
    nrst <= 1'b1;
    u_host.rd_reg(CLK_CFG_ADDR, rv);
    check(rv, CLK_CFG_RESET);
    u_host.rd_reg(STATUS_ADDR, rv);
    check(rv, STATUS_RESET);
    u_host.wr_reg(STATUS_ADDR, 8'hff);
    u_host.rd_reg(5'h1f, rv);
    check(rv, READ_IDLE);
    u_host.rd_reg(STATUS_ADDR, rv);
    check(rv, 8'h00);
    // config readback and line drive source
    for (k = 0; k < 8; k++) begin
      cfg = $random(seed) & 32'hdc;
      u_host.wr_reg(CLK_CFG_ADDR, 8'(cfg | 32'h20));
      @(posedge core_clk);
      // clock enable low: line outputs must freeze at this edge's selection
      held = cfg[6] ? {tx_soft, drv_soft} : {tx_pin, drv_pin};
      ce <= 1'b0;
      {tx_pin, drv_pin, tx_soft, drv_soft} <= 8'($random(seed));
      cyc(4);
      check({4'h0, line_tx, line_en}, {4'h0, held});
      ce <= 1'b1;
      cyc(5);
      u_host.rd_reg(CLK_CFG_ADDR, rv);
      check(rv, 8'(cfg));
      check({4'h0, line_tx, line_en}, {4'h0, cfg[6] ? {tx_soft, drv_soft} : {tx_pin, drv_pin}});
      check(8'(clk_sel), 8'(SRC_INTERNAL));
    end
    // random comparator steps against the status model
    for (k = 0; k < 24; k++) begin
      cfg = $random(seed) & 32'h80;
      u_host.wr_reg(CLK_CFG_ADDR, 8'(cfg));
      @(posedge core_clk);
      sense <= cssb_sense_t'(6'($random(seed)));
      #1;
      cnt = {sense.thermal_off_in,
        sense.temp_above_warn | (~sense.temp_below_release & live[2]),
        sense.supply_below_uv,
        sense.supply_below_warn | (~sense.supply_above_release & live[0])};
      lat = lat | (cnt & ~live);
      live = cnt;
      cyc(5);
      check(8'(irq), 8'(|lat[3:1] | (lat[0] & cfg[7])));
      if (k[0]) begin
        u_host.rd_reg(STATUS_ADDR, rv);
        check(rv, 8'((lat << 4) | live));
        lat = 0;
        cyc(1);
        check(8'(irq), 8'h00);
      end
    end
    // divider codes on the external source, then output disabled
    for (k = 0; k < 5; k++) begin
      u_host.wr_reg(CLK_CFG_ADDR, 8'(k < 4 ? 32'h12 | (k << 2) : 32'h02));
      cyc(20);
      check(8'(clk_sel), 8'(SRC_EXTERNAL));
      cnt = 0;
      prv = clk_out;
      repeat (240) begin
        @(posedge core_clk);
        #1 cnt += (clk_out !== prv);
        prv = clk_out;
      end
      check(8'(cnt >= divs[k] - 1 && cnt <= divs[k] + 1), 8'h01);
    end
    // crystal source dies, fallback, then recovers
    u_host.wr_reg(CLK_CFG_ADDR, 8'h01);
    cyc(20);
    check({6'h0, xtal_on, clk_sel == SRC_CRYSTAL}, 8'h03);
    @(posedge core_clk);
    xtal_run <= 1'b0;
    cnt = 0;
    while (clk_sel !== SRC_INTERNAL && cnt < 100) begin
      cyc(1);
      cnt++;
    end
    check(8'(cnt >= 35 && cnt <= 50), 8'h01);
    if (cnt < 100) begin
      u_host.rd_reg(CLK_CFG_ADDR, rv);
      check(rv, 8'h21);
      @(posedge core_clk);
      xtal_run <= 1'b1;
      cyc(40);
      u_host.rd_reg(CLK_CFG_ADDR, rv);
      check(rv, 8'h01);
      check(8'(clk_sel), 8'(SRC_CRYSTAL));
    end
    print_verdict();
  end
endmodule
